/* inc/attr_params.svh */
// Register map, field positions, reset values and codes for the trigger/offset-cal register bank
// What this block does
// - Manual trigger clear: trigger follows external pin
// - Writing one fires one trigger, self-clears
// - Mode zero disables correction, clears value
// - Nonzero mode averages two-to-(9+code) samples
// - Status sets when averaging run finishes
// - One calibration control shared by eight channels
`ifndef ATTR_PARAMS_SVH
`define ATTR_PARAMS_SVH

// Register addresses
`define ATTR_ADDR_W 13
`define ATTR_OFS_ROUTE 13'h0109
`define ATTR_OFS_PROFILE 13'h010C
`define ATTR_OFS_RSVD_A 13'h010D
`define ATTR_OFS_RSVD_B 13'h010E
`define ATTR_OFS_CAL 13'h010F

// Reset values
`define ATTR_RST_ROUTE 8'h00
`define ATTR_RST_PROFILE 8'h00
`define ATTR_RST_RSVD 8'hFF
`define ATTR_RST_CAL 8'h00

// Field positions
`define ATTR_ROUTE_EN_BIT 4
`define ATTR_ROUTE_CH_LSB 0
`define ATTR_PROF_TRIG_BIT 5
`define ATTR_PROF_IDX_LSB 0
`define ATTR_CAL_MODE_LSB 1
`define ATTR_CAL_STAT_BIT 0

// Calibration codes
`define ATTR_CAL_OFF 3'h0
`define ATTR_CAL_EXP_BASE 5'h09

`endif

/* inc/attr_pkg.sv */
// Types shared by the trigger/offset-cal register bank
package attr_pkg;
  // One signed converter sample
  typedef logic signed [13:0] attr_adc_t;
  // Samples of all eight channels
  typedef attr_adc_t [7:0] attr_chan_vec_t;
  // Test routing control
  typedef struct packed {
    logic testEnable; // Route filter output to outputs
    logic [2:0] channel; // Channel chosen, 0 is channel A
  } attr_route_t;
  // Calibration control and status
  typedef struct packed {
    logic [2:0] mode; // Averaging code
    logic done; // Run finished
  } attr_cal_t;
  // Calibration sequencer states
  typedef enum logic [2:0] {
    ATTR_IDLE = 3'b001,
    ATTR_RUN = 3'b010,
    ATTR_DONE = 3'b100
  } attr_state_t;
endpackage : attr_pkg

/* rtl/attr_regs.sv */
// Trigger, test routing and offset calibration register bank
`timescale 1ns/100ps
`include "attr_params.svh"
module attr_regs
  import attr_pkg::*;
#(
  parameter int CHANNELS = 8, // Receive channels
  parameter int ACC_W = 31 // Accumulator width, sample plus 2^16 growth and one spare bit
) (
  input wire logic clock, // 125 MHz sample clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [`ATTR_ADDR_W-1:0] regAddr, // Register address
  input wire logic regWrite, // Write strobe, one cycle
  input wire logic regRead, // Read strobe, one cycle
  input wire logic [7:0] regWdata, // Write data
  output logic [7:0] regRdata, // Read data, valid cycle after read
  input wire logic triggerPin, // External transmit trigger pin
  output logic transmitTrigger, // Trigger to the transmit logic
  output logic [3:0] profileIndex, // Active profile index
  input wire logic [7:0] filterOutPos, // Filter test output, positive leg
  input wire logic [7:0] filterOutNeg, // Filter test output, negative leg
  output logic generalOutputTwo, // Routed positive leg
  output logic generalOutputThree, // Routed negative leg
  input wire logic sampleValid, // Sample strobe
  input wire attr_chan_vec_t sampleData, // Samples of all channels
  output logic correctionEnable, // Offset correction active
  output attr_chan_vec_t correctionValue // Per-channel offset estimate
);

  // Sample count for a code, minus one
  function automatic logic [16:0] calLast(input logic [2:0] code);
    calLast = 17'((18'h00001 << (`ATTR_CAL_EXP_BASE + 5'(code))) - 18'h00001);
  endfunction : calLast

  // Shift that turns a sum into an average
  function automatic logic [4:0] calShift(input logic [2:0] code);
    calShift = `ATTR_CAL_EXP_BASE + 5'(code);
  endfunction : calShift

  // Register fields and calibration sequencer state
  attr_route_t route; // Test routing register
  logic manualTrig; // Manual trigger bit
  logic [3:0] profile; // Profile index field
  attr_cal_t cal; // Calibration register
  attr_state_t state; // Sequencer state
  attr_state_t next_state; // Sequencer next state
  logic [16:0] sampleCount; // Samples taken in this run
  logic signed [ACC_W-1:0] accum [CHANNELS]; // Per-channel sums

  // Decode
  wire selRoute = regAddr == `ATTR_OFS_ROUTE;
  wire selProfile = regAddr == `ATTR_OFS_PROFILE;
  wire selRsvd = (regAddr == `ATTR_OFS_RSVD_A) || (regAddr == `ATTR_OFS_RSVD_B);
  wire selCal = regAddr == `ATTR_OFS_CAL;
  wire wrRoute = regWrite && selRoute;
  wire wrProfile = regWrite && selProfile;
  wire wrCal = regWrite && selCal;
  wire [2:0] wrMode = regWdata[`ATTR_CAL_MODE_LSB +: 3];
  wire calStart = wrCal && (wrMode != `ATTR_CAL_OFF);
  wire calClear = wrCal && (wrMode == `ATTR_CAL_OFF);
  wire lastSample = sampleValid && (sampleCount == calLast(cal.mode));
  wire [4:0] avgShift = calShift(cal.mode);

  // Read mux; unmapped addresses read zero
  // Reserved registers return their fixed pattern and ignore writes
  wire [7:0] rdRoute = {3'h0, route.testEnable, 1'b0, route.channel};
  wire [7:0] rdProfile = {2'h0, manualTrig, 1'b0, profile};
  wire [7:0] rdCal = {4'h0, cal.mode, cal.done};
  wire [7:0] rdMux = selRoute ? rdRoute :
                     selProfile ? rdProfile :
                     selRsvd ? `ATTR_RST_RSVD :
                     selCal ? rdCal : 8'h00;

  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ATTR_IDLE: begin
        if (calStart) begin
          next_state = ATTR_RUN;
        end
      end
      ATTR_RUN: begin
        if (calClear) begin
          next_state = ATTR_IDLE;
        end else if (calStart) begin
          next_state = ATTR_RUN; // Rewrite restarts the run
        end else if (lastSample) begin
          next_state = ATTR_DONE;
        end
      end
      ATTR_DONE: begin
        if (calClear) begin
          next_state = ATTR_IDLE;
        end else if (calStart) begin
          next_state = ATTR_RUN;
        end
      end
      default: begin
        next_state = ATTR_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= ATTR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Test routing register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      route <= attr_route_t'(`ATTR_RST_ROUTE); // Channel A by default
    end else if (wrRoute) begin
      route.testEnable <= regWdata[`ATTR_ROUTE_EN_BIT];
      route.channel <= regWdata[`ATTR_ROUTE_CH_LSB +: 3];
    end
  end

  // Profile index and manual trigger bit
  always_ff @(posedge clock) begin
    if (!rstn) begin
      profile <= 4'(`ATTR_RST_PROFILE);
      manualTrig <= 1'b0;
    end else begin
      if (wrProfile) begin
        profile <= regWdata[`ATTR_PROF_IDX_LSB +: 4];
      end
      // Set by a write of one, cleared by hardware the next cycle
      manualTrig <= wrProfile && regWdata[`ATTR_PROF_TRIG_BIT];
    end
  end

  // Transmit trigger: pin when manual bit clear, one pulse when set
  always_ff @(posedge clock) begin
    if (!rstn) begin
      transmitTrigger <= 1'b0;
    end else if (manualTrig) begin
      transmitTrigger <= 1'b1;
    end else begin
      transmitTrigger <= triggerPin;
    end
  end

  // Calibration control and status
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cal <= attr_cal_t'(`ATTR_RST_CAL);
    end else if (wrCal) begin
      cal.mode <= wrMode;
      cal.done <= 1'b0; // New setting restarts or stops the run
    end else if (state == ATTR_RUN && lastSample) begin
      cal.done <= 1'b1;
    end
  end

  // Sample counter shared by all channels
  // Any calibration write restarts the count from zero
  always_ff @(posedge clock) begin
    if (!rstn || wrCal) begin
      sampleCount <= 17'h00000;
    end else if (state == ATTR_RUN && sampleValid) begin
      sampleCount <= sampleCount + 17'h00001;
    end
  end

  // Per-channel accumulators, one global run for all
  always_ff @(posedge clock) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (!rstn || wrCal) begin
        accum[i] <= '0;
      end else if (state == ATTR_RUN && sampleValid) begin
        accum[i] <= accum[i] + ACC_W'(sampleData[i]);
      end
    end
  end

  // Correction value: average on completion, zero when disabled
  always_ff @(posedge clock) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (!rstn || calClear) begin
        correctionValue[i] <= '0;
      end else if (state == ATTR_RUN && lastSample) begin
        // The sum must include this cycle's sample, which the accumulator has not taken yet
        // Arithmetic shift keeps the sign of the average
        correctionValue[i] <= attr_adc_t'((accum[i] + ACC_W'(sampleData[i])) >>> avgShift);
      end
    end
  end

  // Correction enable follows a nonzero mode once a run has finished
  always_ff @(posedge clock) begin
    if (!rstn || calClear) begin
      correctionEnable <= 1'b0;
    end else if (state == ATTR_RUN && lastSample) begin
      correctionEnable <= 1'b1;
    end
  end

  // Filter test routing to the general outputs
  always_ff @(posedge clock) begin
    if (!rstn || !route.testEnable) begin
      generalOutputTwo <= 1'b0;
      generalOutputThree <= 1'b0;
    end else begin
      generalOutputTwo <= filterOutPos[route.channel];
      generalOutputThree <= filterOutNeg[route.channel];
    end
  end

  // Read data register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= rdMux;
    end
  end

  assign profileIndex = profile; // Drive profile from register

endmodule : attr_regs

/* testbench/attr_host.sv */
// Host model driving the register port
`timescale 1ns/100ps
`include "attr_params.svh"
module attr_host (
  input wire logic clock, // Clock
  output logic [`ATTR_ADDR_W-1:0] regAddr, // Address
  output logic regWrite, // Write strobe
  output logic regRead, // Read strobe
  output logic [7:0] regWdata, // Write data
  input wire logic [7:0] regRdata // Read data
);
  // Idle port at time zero
  initial begin
    regAddr = '0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 8'h00;
  end
  // One-cycle write; a one in the trigger bit fires it
  task automatic wr(input logic [`ATTR_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regWdata <= ~d; // Stale data must not linger
  endtask : wr
  // One-cycle read, data taken after the answering edge
  task automatic rd(input logic [`ATTR_ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd
endmodule : attr_host

/* testbench/attr_regs_assertions.sv */
// Checker for the trigger/offset-cal register bank
`timescale 1ns/100ps
`include "attr_params.svh"
module attr_regs_checker (
  input wire logic clock, // Clock
  input wire logic rstn, // Reset
  input wire logic [`ATTR_ADDR_W-1:0] regAddr, // Address
  input wire logic regWrite, // Write
  input wire logic regRead, // Read
  input wire logic [7:0] regWdata, // Write data
  input wire logic [7:0] regRdata, // Read data
  input wire logic triggerPin, // Pin
  input wire logic transmitTrigger, // Trigger
  input wire logic [3:0] profileIndex, // Profile
  input wire logic sampleValid, // Sample strobe
  input wire logic correctionEnable // Correction on
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Decoded accesses
  wire logic prof = regAddr == `ATTR_OFS_PROFILE;
  wire logic fire = regWrite && prof && regWdata[`ATTR_PROF_TRIG_BIT];
  wire logic rsvd = regAddr == `ATTR_OFS_RSVD_A || regAddr == `ATTR_OFS_RSVD_B;
  wire logic cal = regAddr == `ATTR_OFS_CAL;
  wire logic mapped = rsvd || prof || cal || regAddr == `ATTR_OFS_ROUTE;
  // Manual fire: request, then one pulse two edges on
  sequence s_fire; fire; endsequence
  sequence s_pulse; transmitTrigger; endsequence
  property p_fire; s_fire |-> ##2 s_pulse; endproperty
  a_fire: assert property (p_fire) else $error("no manual trigger");
  property p_pin; !fire |-> ##2 (transmitTrigger == $past(triggerPin)); endproperty
  a_pin: assert property (p_pin) else $error("trigger not from pin");
  property p_prof; regWrite && prof |=> profileIndex == $past(regWdata[3:0]); endproperty
  a_prof: assert property (p_prof) else $error("profile not written");
  property p_off; regWrite && cal && regWdata[3:1] == 3'h0 |=> !correctionEnable; endproperty
  a_off: assert property (p_off) else $error("correction not off");
  property p_done; $rose(correctionEnable) |-> $past(sampleValid); endproperty
  a_done: assert property (p_done) else $error("done without sample");
  property p_rsvd; regRead && rsvd |=> regRdata == 8'hFF; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read wrong");
  property p_unmap; regRead && !mapped |=> regRdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
  property p_hold; !regRead |=> $stable(regRdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule : attr_regs_checker
bind attr_regs attr_regs_checker u_chk (.clock(clock), .rstn(rstn), .regAddr(regAddr),
  .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
  .triggerPin(triggerPin), .transmitTrigger(transmitTrigger), .profileIndex(profileIndex),
  .sampleValid(sampleValid), .correctionEnable(correctionEnable));

/* testbench/attr_regs_test.sv */
// Testbench for the trigger/offset-cal register bank
`timescale 1ns/100ps
`include "attr_params.svh"
module attr_regs_test
  import attr_pkg::*;
  ;
  logic clock = 1'b0; // Clock
  logic rstn = 1'b0; // Reset, active low
  logic [`ATTR_ADDR_W-1:0] regAddr; // Address
  logic regWrite, regRead, transmitTrigger, generalOutputTwo, generalOutputThree;
  logic triggerPin = 1'b0; // External trigger
  logic sampleValid = 1'b0; // Sample strobe
  logic correctionEnable; // Correction on
  logic [7:0] regWdata, regRdata, rdata;
  logic [7:0] filterOutPos = 8'h00; // Filter legs
  logic [7:0] filterOutNeg = 8'h00;
  logic [3:0] profileIndex; // Profile
  attr_chan_vec_t sampleData = '0; // Samples
  attr_chan_vec_t correctionValue; // Estimates
  int errTotal = 0;
  int samplesChecked = 0;
  int cycles = 0;
  always #4 clock = ~clock;
  attr_host host (.clock(clock), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata));
  attr_regs dut (.clock(clock), .rstn(rstn), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .triggerPin(triggerPin),
    .transmitTrigger(transmitTrigger), .profileIndex(profileIndex),
    .filterOutPos(filterOutPos), .filterOutNeg(filterOutNeg),
    .generalOutputTwo(generalOutputTwo), .generalOutputThree(generalOutputThree),
    .sampleValid(sampleValid), .sampleData(sampleData),
    .correctionEnable(correctionEnable), .correctionValue(correctionValue));
  // Compare and count
  task chk(input logic [111:0] got, input logic [111:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  // Read one register and compare
  task rdck(input logic [`ATTR_ADDR_W-1:0] a, input logic [7:0] e);
    host.rd(a, rdata);
    chk(112'(rdata), 112'(e));
  endtask : rdck
  // Reset values, refused write, unmapped read
  task t_map;
    rdck(`ATTR_OFS_ROUTE, `ATTR_RST_ROUTE);
    rdck(`ATTR_OFS_PROFILE, `ATTR_RST_PROFILE);
    rdck(`ATTR_OFS_CAL, `ATTR_RST_CAL);
    host.wr(`ATTR_OFS_RSVD_A, 8'h00);
    rdck(`ATTR_OFS_RSVD_A, `ATTR_RST_RSVD);
    rdck(`ATTR_OFS_RSVD_B, `ATTR_RST_RSVD);
    rdck(13'h0100, 8'h00);
  endtask : t_map
  // Manual fire, self clear, then pin follows
  task t_trig;
    host.wr(`ATTR_OFS_PROFILE, 8'h25);
    @(posedge clock);
    #1 chk(112'(transmitTrigger), 112'(1'b1));
    chk(112'(profileIndex), 112'(4'h5));
    @(posedge clock);
    #1 chk(112'(transmitTrigger), 112'(1'b0));
    rdck(`ATTR_OFS_PROFILE, 8'h05);
    @(posedge clock);
    triggerPin <= 1'b1;
    @(posedge clock);
    triggerPin <= 1'b0;
    #1 chk(112'(transmitTrigger), 112'(1'b1));
  endtask : t_trig
  // Route channel C legs, swap them, then disable
  task t_route;
    @(posedge clock);
    filterOutPos <= 8'h04;
    filterOutNeg <= 8'hFB;
    host.wr(`ATTR_OFS_ROUTE, 8'h12);
    @(posedge clock);
    #1 chk(112'({generalOutputTwo, generalOutputThree}), 112'(2'b10));
    @(posedge clock);
    filterOutPos <= 8'hFB;
    filterOutNeg <= 8'h04;
    @(posedge clock);
    #1 chk(112'({generalOutputTwo, generalOutputThree}), 112'(2'b01));
    host.wr(`ATTR_OFS_ROUTE, 8'h02);
    @(posedge clock);
    #1 chk(112'({generalOutputTwo, generalOutputThree}), 112'(2'b00));
  endtask : t_route
  // Run one averaging code to the exact count, then turn it off
  task automatic t_cal(input logic [2:0] m);
    int n = 1 << (9 + m);
    host.wr(`ATTR_OFS_CAL, {4'h0, m, 1'b0});
    sampleValid <= 1'b1;
    repeat (n - 1) @(posedge clock);
    #1 chk(112'(correctionEnable), 112'(1'b0));
    @(posedge clock);
    sampleValid <= 1'b0;
    #1 chk(112'(correctionEnable), 112'(1'b1));
    chk(correctionValue, sampleData);
    rdck(`ATTR_OFS_CAL, {4'h0, m, 1'b1});
    host.wr(`ATTR_OFS_CAL, 8'h00);
    #1 chk(correctionValue, 112'h0);
    chk(112'(correctionEnable), 112'(1'b0));
    rdck(`ATTR_OFS_CAL, 8'h00);
  endtask : t_cal
  // Verdict and end of run
  task results;
    if (errTotal == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // Hang guard; the runs take about 73000 cycles, most of it the top code
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      errTotal++;
      results();
    end
  end
  // Main sequence
  initial begin
    for (int i = 0; i < 8; i++) sampleData[i] = 14'(i * 37 - 100);
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    t_map();
    t_trig();
    t_route();
    for (int m = 1; m < 4; m++) t_cal(3'(m));
    t_cal(3'h7); // Top code, two to the sixteenth samples
    results();
  end
endmodule : attr_regs_test
